// ===== logic/gpm_pkg.sv
// Package of constants and types for the gauge power-mode sequencer.
package gpm_pkg;

  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned INSERT_DETECT_US = 3000;
  localparam int unsigned INSERT_CYCLES    = INSERT_DETECT_US * CLK_MHZ;
  localparam int unsigned CAL_CYCLES       = 64;
  localparam int unsigned SLEEP_PERIOD     = 1024;
  localparam int unsigned MEAS_CYCLES      = 16;
  localparam int unsigned CKSUM_W          = 16;
  localparam int unsigned CNT_W            = 8;
  localparam int unsigned MEM_DEPTH        = 16;
  localparam int unsigned MEM_AW           = 4;
  localparam int unsigned TEMP_W           = 12;
  localparam logic [1:0]  PFC_SUSPEND      = 2'h1;
  localparam logic [CKSUM_W-1:0] CKSUM_RST = 16'h0000;

  typedef enum logic [1:0] {
    GPM_RST_FULL,
    GPM_RST_PARTIAL,
    GPM_RST_WATCHDOG,
    GPM_RST_OTHER
  } gpm_rst_kind_t;

endpackage : gpm_pkg

// ===== logic/gpm_ckmem.sv
// Working memory with a running checksum and partial-reset check.
`timescale 1ns/10ps
module gpm_ckmem (
  input  wire logic                              clk,
  input  wire logic                              reset,
  input  wire logic                              wr_en,
  input  wire logic [gpm_pkg::MEM_AW-1:0]        wr_addr,
  input  wire logic [gpm_pkg::CKSUM_W-1:0]       wr_data,
  input  wire logic                              check_start,
  output logic                                   check_done,
  output logic                                   check_fail
);

  logic [gpm_pkg::CKSUM_W-1:0] mem [gpm_pkg::MEM_DEPTH];
  logic [gpm_pkg::CKSUM_W-1:0] stored_sum;
  logic [gpm_pkg::CKSUM_W-1:0] calc_sum;
  logic [gpm_pkg::MEM_AW-1:0]  scan_addr;
  logic                        scanning;
  logic                        wiping;

  // Stored checksum follows every change, as a sum of all words.
  always_ff @(posedge clk) begin
    if (reset) begin
      stored_sum <= gpm_pkg::CKSUM_RST;
    end else if (wr_en && !scanning && !wiping) begin
      stored_sum <= stored_sum - mem[wr_addr] + wr_data;
    end else if (wiping) begin
      stored_sum <= gpm_pkg::CKSUM_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || wiping) begin
      for (int i = 0; i < gpm_pkg::MEM_DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (wr_en && !scanning) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Recompute by walking memory; mismatch wipes it all.
  always_ff @(posedge clk) begin
    if (reset) begin
      scanning   <= 1'b0;
      wiping     <= 1'b0;
      scan_addr  <= '0;
      calc_sum   <= '0;
      check_done <= 1'b0;
      check_fail <= 1'b0;
    end else begin
      check_done <= 1'b0;
      wiping     <= 1'b0;
      if (check_start && !scanning) begin
        scanning  <= 1'b1;
        scan_addr <= '0;
        calc_sum  <= '0;
      end else if (scanning) begin
        calc_sum  <= calc_sum + mem[scan_addr];
        scan_addr <= scan_addr + 1'b1;
        if (scan_addr == gpm_pkg::MEM_AW'(gpm_pkg::MEM_DEPTH - 1)) begin
          scanning   <= 1'b0;
          check_done <= 1'b1;
          check_fail <= (calc_sum + mem[scan_addr]) != stored_sum;
          wiping     <= (calc_sum + mem[scan_addr]) != stored_sum;
        end
      end
    end
  end

endmodule : gpm_ckmem

// ===== logic/gpm_seq.sv
// Power-mode sequencer, charge guard and reset bookkeeping of the gauge.
`timescale 1ns/10ps

module gpm_seq #(
  parameter int unsigned INSERT_CYCLES = gpm_pkg::INSERT_CYCLES
) (
  input  wire logic                              clk,
  input  wire logic                              reset,
  input  wire logic signed [gpm_pkg::TEMP_W-1:0] temperature,
  input  wire logic signed [gpm_pkg::TEMP_W-1:0] inhibit_low,
  input  wire logic signed [gpm_pkg::TEMP_W-1:0] inhibit_high,
  input  wire logic signed [gpm_pkg::TEMP_W-1:0] suspend_low,
  input  wire logic signed [gpm_pkg::TEMP_W-1:0] suspend_high,
  input  wire logic signed [gpm_pkg::TEMP_W-1:0] temp_hys,
  input  wire logic [1:0]                        pin_function_code,
  input  wire logic                              sleep_enable,
  input  wire logic                              good_pin_override,
  input  wire logic                              sense_select_high,
  input  wire logic                              sense_select_low,
  input  wire logic                              mean_current_low,
  input  wire logic                              hib_current_low,
  input  wire logic                              cell_below_hib_volt,
  input  wire logic                              hibernate_request,
  input  wire logic                              wake_comparator,
  input  wire logic                              battery_present,
  input  wire logic                              host_cmd,
  input  wire logic                              link_clock,
  input  wire logic                              own_address_cmd,
  input  wire logic                              soft_reset,
  input  wire logic [1:0]                        soft_reset_kind,
  input  wire logic [1:0]                        reset_count_sel,
  input  wire logic                              mem_wr_en,
  input  wire logic [gpm_pkg::MEM_AW-1:0]        mem_wr_addr,
  input  wire logic [gpm_pkg::CKSUM_W-1:0]       mem_wr_data,
  input  wire logic                              ocv_done,
  input  wire logic                              cal_done,
  input  wire logic                              profile_done,
  output logic                                   battery_good_pin,
  output logic                                   charge_inhibit_flag,
  output logic                                   charge_suspend_flag,
  output logic [2:0]                             power_mode,
  output logic                                   ocv_start,
  output logic                                   cal_start,
  output logic                                   profile_start,
  output logic                                   measure_active,
  output logic                                   gauging_active,
  output logic                                   ocv_valid,
  output logic [gpm_pkg::CNT_W-1:0]              reset_count,
  output logic                                   mem_reinit
);

  typedef enum logic [2:0] {
    GPM_NORMAL,
    GPM_CAL,
    GPM_SLEEP,
    GPM_HIBERNATE,
    GPM_INSERT_WAIT,
    GPM_INIT_OCV,
    GPM_INIT_PROFILE
  } gpm_state_t;

  gpm_state_t state;
  logic [2:0] sync_in0;
  logic [2:0] sync_in1;
  logic [1:0] lclk_s;
  logic       lclk_prev;
  logic [31:0] ins_cnt;
  logic [15:0] sleep_cnt;
  logic       hib_by_volt;
  logic       wake_en;
  logic       in_inhibit_ok;
  logic       out_inhibit;
  logic       out_suspend;
  logic       link_edge;
  logic       present_s;
  logic       wake_s;
  logic       own_s;
  logic       next_good;
  logic [gpm_pkg::CNT_W-1:0] counters [4];
  logic       ck_done;
  logic       ck_fail;

  // Pins cross in through two flops; the first flop feeds only the second.
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_in0 <= '0;
      sync_in1 <= '0;
      lclk_s   <= '0;
      lclk_prev <= 1'b0;
    end else begin
      sync_in0  <= {own_address_cmd, wake_comparator, battery_present};
      sync_in1  <= sync_in0;
      lclk_s    <= {lclk_s[0], link_clock};
      lclk_prev <= lclk_s[1];
    end
  end

  assign present_s = sync_in1[0];
  assign wake_s    = sync_in1[1];
  // Address match counts only when the link clock is really running.
  assign own_s     = sync_in1[2];
  assign link_edge = lclk_s[1] & ~lclk_prev;

  assign wake_en = sense_select_high | sense_select_low;
  assign out_inhibit = (temperature < inhibit_low) ||
                       (temperature > inhibit_high);
  assign in_inhibit_ok = (temperature >= inhibit_low + temp_hys) &&
                         (temperature <= inhibit_high - temp_hys);
  assign out_suspend = (temperature < suspend_low) ||
                       (temperature > suspend_high);

  always_ff @(posedge clk) begin
    if (reset) begin
      charge_inhibit_flag <= 1'b0;
    end else if (out_inhibit) begin
      charge_inhibit_flag <= 1'b1;
    end else if (in_inhibit_ok) begin
      charge_inhibit_flag <= 1'b0;
    end
  end

  // Setting wins over clearing when both are seen together.
  always_ff @(posedge clk) begin
    if (reset) begin
      charge_suspend_flag <= 1'b0;
    end else if ((pin_function_code == gpm_pkg::PFC_SUSPEND) &&
                 out_suspend) begin
      charge_suspend_flag <= 1'b1;
    end else if (in_inhibit_ok) begin
      charge_suspend_flag <= 1'b0;
    end
  end

  // Mode sequencer.
  always_ff @(posedge clk) begin
    if (reset) begin
      state       <= GPM_INSERT_WAIT;
      ins_cnt     <= '0;
      sleep_cnt   <= '0;
      hib_by_volt <= 1'b0;
      ocv_valid   <= 1'b0;
    end else begin
      unique case (state)
        GPM_NORMAL: begin
          if (!present_s) begin
            state     <= GPM_INSERT_WAIT;
            ocv_valid <= 1'b0;
          end else if (ocv_valid && cell_below_hib_volt) begin
            state       <= GPM_HIBERNATE;
            hib_by_volt <= 1'b1;
          end else if (ocv_valid && hibernate_request && hib_current_low) begin
            state       <= GPM_HIBERNATE;
            hib_by_volt <= 1'b0;
          end else if (sleep_enable && mean_current_low) begin
            state <= GPM_CAL;
          end
        end
        GPM_CAL: begin
          if (!present_s) begin
            state <= GPM_INSERT_WAIT;
          end else if (cal_done) begin
            state     <= GPM_SLEEP;
            sleep_cnt <= '0;
          end
        end
        GPM_SLEEP: begin
          sleep_cnt <= (sleep_cnt == 16'(gpm_pkg::SLEEP_PERIOD - 1)) ?
                       '0 : sleep_cnt + 16'h0001;
          if (!present_s) begin
            state <= GPM_INSERT_WAIT;
          end else if (!mean_current_low || (wake_en && wake_s)) begin
            state <= GPM_NORMAL;
          end
        end
        GPM_HIBERNATE: begin
          if (own_s && link_edge) begin
            state     <= GPM_INSERT_WAIT;
            ocv_valid <= 1'b0;
            ins_cnt   <= '0;
          end
        end
        GPM_INSERT_WAIT: begin
          if (!present_s) begin
            ins_cnt <= '0;
          end else if (ins_cnt == INSERT_CYCLES - 1) begin
            state   <= GPM_INIT_OCV;
            ins_cnt <= '0;
          end else begin
            ins_cnt <= ins_cnt + 32'h00000001;
          end
        end
        GPM_INIT_OCV: begin
          if (ocv_done) begin
            state     <= GPM_INIT_PROFILE;
            ocv_valid <= 1'b1;
          end
        end
        GPM_INIT_PROFILE: begin
          if (profile_done) begin
            state <= GPM_NORMAL;
          end
        end
      endcase
    end
  end

  // Good pin: inactive until voltage reading, in hibernate unless entered on low voltage with override, and on inhibit.
  always_comb begin
    next_good = ocv_valid && !charge_inhibit_flag &&
                (state != GPM_INSERT_WAIT) && (state != GPM_INIT_OCV);
    if (state == GPM_HIBERNATE) begin
      next_good = hib_by_volt && good_pin_override &&
                  !charge_inhibit_flag;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      battery_good_pin <= 1'b0;
      power_mode       <= 3'h4;
      ocv_start        <= 1'b0;
      cal_start        <= 1'b0;
      profile_start    <= 1'b0;
      measure_active   <= 1'b0;
      gauging_active   <= 1'b0;
    end else begin
      battery_good_pin <= next_good;
      power_mode       <= 3'(state);
      ocv_start        <= (state == GPM_INIT_OCV);
      cal_start        <= (state == GPM_CAL);
      profile_start    <= (state == GPM_INIT_PROFILE);
      // Sleep measures only in a short burst each period.
      measure_active   <= (state == GPM_NORMAL) ||
                          ((state == GPM_SLEEP) &&
                           (sleep_cnt < 16'(gpm_pkg::MEAS_CYCLES))) ||
                          ((state == GPM_INSERT_WAIT) && host_cmd);
      gauging_active   <= (state == GPM_NORMAL) ||
                          (state == GPM_SLEEP);
    end
  end

  // Per-type software reset counters.
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        counters[i] <= '0;
      end
      reset_count <= '0;
    end else begin
      if (soft_reset) begin
        counters[soft_reset_kind] <= counters[soft_reset_kind] + 1'b1;
      end
      reset_count <= counters[reset_count_sel];
    end
  end

  gpm_ckmem u_ckmem (
    .clk         (clk),
    .reset       (reset),
    .wr_en       (mem_wr_en),
    .wr_addr     (mem_wr_addr),
    .wr_data     (mem_wr_data),
    .check_start (soft_reset &&
                  (soft_reset_kind == 2'(gpm_pkg::GPM_RST_PARTIAL))),
    .check_done  (ck_done),
    .check_fail  (ck_fail)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_reinit <= 1'b0;
    end else begin
      mem_reinit <= ck_done && ck_fail;
    end
  end

endmodule : gpm_seq

// ===== verification/gpm_seq_props.sv
// Port-level checks for the gauge power-mode sequencer.
`timescale 1ns/10ps
module gpm_seq_props (
  input wire logic                              clk,
  input wire logic                              reset,
  input wire logic signed [gpm_pkg::TEMP_W-1:0] temperature,
  input wire logic signed [gpm_pkg::TEMP_W-1:0] inhibit_low,
  input wire logic signed [gpm_pkg::TEMP_W-1:0] inhibit_high,
  input wire logic signed [gpm_pkg::TEMP_W-1:0] suspend_low,
  input wire logic signed [gpm_pkg::TEMP_W-1:0] suspend_high,
  input wire logic signed [gpm_pkg::TEMP_W-1:0] temp_hys,
  input wire logic [1:0]                        pin_function_code,
  input wire logic                              good_pin_override,
  input wire logic                              own_address_cmd,
  input wire logic                              battery_good_pin,
  input wire logic                              charge_inhibit_flag,
  input wire logic                              charge_suspend_flag,
  input wire logic [2:0]                        power_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence inh_out;
    temperature < inhibit_low || temperature > inhibit_high;
  endsequence
  sequence inh_in;
    temperature >= inhibit_low + temp_hys &&
      temperature <= inhibit_high - temp_hys;
  endsequence
  sequence sus_out;
    temperature < suspend_low || temperature > suspend_high;
  endsequence
  // Eight quiet cycles outlast both synchronisers and the mode lag.
  sequence quiet_link;
    (!own_address_cmd)[*8];
  endsequence
  a_inhibit_set: assert property (
    inh_out |=> charge_inhibit_flag ##1 !battery_good_pin)
    else $error("inhibit flag or good pin missed");
  a_inhibit_clear: assert property (
    inh_in |=> !charge_inhibit_flag)
    else $error("inhibit flag not cleared");
  a_suspend_set: assert property (
    pin_function_code == gpm_pkg::PFC_SUSPEND ##0 sus_out
    |=> charge_suspend_flag)
    else $error("suspend flag missed");
  a_suspend_clear: assert property (
    inh_in |=> !charge_suspend_flag)
    else $error("suspend flag not cleared");
  a_hib_pin_low: assert property (
    (power_mode == 3'h3 && !good_pin_override)[*3] |-> !battery_good_pin)
    else $error("good pin high in hibernate");
  a_hib_stays_put: assert property (
    quiet_link ##0 power_mode == 3'h3 |=> power_mode == 3'h3)
    else $error("hibernate left without own command");
  a_sleep_via_cal: assert property (
    power_mode == 3'h2 |-> $past(power_mode) inside {3'h1, 3'h2})
    else $error("sleep entered without calibration");
  a_init_step_order: assert property (
    power_mode == 3'h6 |-> $past(power_mode) inside {3'h5, 3'h6})
    else $error("profile step not after voltage step");
  a_ocv_pin_low: assert property (
    power_mode == 3'h5 && !good_pin_override |-> !battery_good_pin)
    else $error("good pin high before voltage reading");
endmodule : gpm_seq_props

// ===== verification/gpm_host_model.sv
// Host processor and charger model facing the gauge sequencer.
`timescale 1ns/10ps
module gpm_host_model (
  input  wire logic battery_good_pin,
  input  wire logic charge_inhibit_flag,
  input  wire logic charge_suspend_flag,
  output logic      link_clock,
  output logic      own_address_cmd,
  output logic      charging
);
  initial begin
    link_clock = 1'b0;
    own_address_cmd = 1'b0;
    charging = 1'b0;
  end
  // The link clock stands low between frames, as a real host leaves it.
  task automatic frame(input logic own);
    #1;
    own_address_cmd = own;
    repeat (9) begin
      #40 link_clock = 1'b1;
      #40 link_clock = 1'b0;
    end
    own_address_cmd = 1'b0;
  endtask : frame
  // Charging starts only inside the inhibit window and stops on suspend.
  // Hibernate drops the good pin unless entered on low voltage with override, so an attached charger simply stalls.
  always @* begin
    if (!battery_good_pin || charge_suspend_flag) begin
      charging = 1'b0;
    end else if (!charge_inhibit_flag) begin
      charging = 1'b1;
    end
  end
endmodule : gpm_host_model

// ===== verification/gpm_seq_tb_top.sv
// Self-checking bench for the gauge power-mode sequencer.
`timescale 1ns/10ps
module gpm_seq_tb_top;
  logic signed [gpm_pkg::TEMP_W-1:0] temperature, inhibit_low, inhibit_high;
  logic signed [gpm_pkg::TEMP_W-1:0] suspend_low, suspend_high, temp_hys;
  logic [1:0]                        pin_function_code, soft_reset_kind;
  logic [1:0]                        reset_count_sel;
  logic [gpm_pkg::MEM_AW-1:0]        mem_wr_addr;
  logic [gpm_pkg::CKSUM_W-1:0]       mem_wr_data;
  logic [2:0]                        power_mode;
  logic [gpm_pkg::CNT_W-1:0]         reset_count;
  logic clk, reset, sleep_enable, good_pin_override, sense_select_high;
  logic sense_select_low, mean_current_low, hib_current_low, host_cmd;
  logic cell_below_hib_volt, hibernate_request, wake_comparator;
  logic battery_present, link_clock, own_address_cmd, soft_reset;
  logic mem_wr_en, ocv_done, cal_done, profile_done, battery_good_pin;
  logic charge_inhibit_flag, charge_suspend_flag, ocv_start, cal_start;
  logic profile_start, measure_active, gauging_active, ocv_valid;
  logic mem_reinit, charging, exp_inh, exp_sus;
  int   n_fail, num_checks, seed, cnt;
  logic signed [gpm_pkg::TEMP_W-1:0] corner [12] = '{-12'sh066, -12'sh064,
    -12'sh05B, -12'sh05A, 12'sh000, 12'sh066, 12'sh064, 12'sh05B, 12'sh05A,
    -12'sh098, -12'sh096, 12'sh098};
  gpm_seq #(.INSERT_CYCLES(20)) dut_u (.clk, .reset, .temperature,
    .inhibit_low, .inhibit_high, .suspend_low, .suspend_high, .temp_hys,
    .pin_function_code, .sleep_enable, .good_pin_override, .sense_select_high,
    .sense_select_low, .mean_current_low, .hib_current_low,
    .cell_below_hib_volt, .hibernate_request, .wake_comparator,
    .battery_present, .host_cmd, .link_clock, .own_address_cmd, .soft_reset,
    .soft_reset_kind, .reset_count_sel, .mem_wr_en, .mem_wr_addr,
    .mem_wr_data, .ocv_done, .cal_done, .profile_done, .battery_good_pin,
    .charge_inhibit_flag, .charge_suspend_flag, .power_mode, .ocv_start,
    .cal_start, .profile_start, .measure_active, .gauging_active, .ocv_valid,
    .reset_count, .mem_reinit);
  gpm_host_model host_u (.battery_good_pin, .charge_inhibit_flag,
    .charge_suspend_flag, .link_clock, .own_address_cmd, .charging);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task automatic wait_mode(input logic [2:0] m, input int lim);
    cnt = 0;
    while (power_mode !== m && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
    chk("mode", power_mode, m);
  endtask : wait_mode
  task automatic finish_init();
    chk("ocv_start", ocv_start, 1'b1);
    pulse(ocv_done);
    wait_mode(3'h6, 10);
    chk("profile_start", profile_start, 1'b1);
    chk("ocv_valid", ocv_valid, 1'b1);
    cycles(2);
    chk("good", battery_good_pin, 1'b1);
    pulse(profile_done);
    wait_mode(3'h0, 10);
  endtask : finish_init
  // Set wins; inside the narrowed window clears; the band between holds.
  function automatic logic next_flag(logic cur, logic set);
    if (set) return 1'b1;
    if (temperature >= inhibit_low + temp_hys &&
        temperature <= inhibit_high - temp_hys) return 1'b0;
    return cur;
  endfunction : next_flag
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  initial begin
    {n_fail, num_checks, cnt, exp_inh, exp_sus} = '0;
    seed = 32'h5FB6185B;
    reset = 1'b1;
    {temperature, pin_function_code, soft_reset_kind, reset_count_sel} = '0;
    {mem_wr_addr, mem_wr_data, sleep_enable, good_pin_override} = '0;
    {sense_select_high, sense_select_low, mean_current_low} = '0;
    {hib_current_low, cell_below_hib_volt, hibernate_request} = '0;
    {wake_comparator, battery_present, host_cmd, soft_reset} = '0;
    {mem_wr_en, ocv_done, cal_done, profile_done} = '0;
    inhibit_low = -12'sh065;
    inhibit_high = 12'sh065;
    suspend_low = -12'sh097;
    suspend_high = 12'sh097;
    temp_hys = 12'sh00A;
    cycles(12);
    chk("mode", power_mode, 3'h4);
    reset = 1'b0;
    host_cmd = 1'b1;
    cycles(2);
    chk("measure", measure_active, 1'b1);
    cycles(2);
    host_cmd = 1'b0;
    cycles(8);
    chk("mode", power_mode, 3'h4);
    chk("measure", measure_active, 1'b0);
    battery_present = 1'b1;
    wait_mode(3'h5, 40);
    chk("good", battery_good_pin, 1'b0);
    finish_init();
    chk("gauge", gauging_active, 1'b1);
    for (int i = 0; i < 52; i++) begin
      temperature = i < 12 ? corner[i] : 12'(2 * ($random(seed) % 90));
      pin_function_code = i < 12 ? 2'h1 : 2'($random(seed));
      exp_inh = next_flag(exp_inh, temperature < inhibit_low ||
                          temperature > inhibit_high);
      exp_sus = next_flag(exp_sus, pin_function_code == 2'h1 &&
                (temperature < suspend_low || temperature > suspend_high));
      cycles(2);
      chk("inhibit", charge_inhibit_flag, exp_inh);
      chk("suspend", charge_suspend_flag, exp_sus);
      chk("good", battery_good_pin, !exp_inh);
      chk("charge", charging, !exp_inh && !exp_sus);
    end
    temperature = '0;
    cycles(4);
    for (int k = 0; k < 2; k++) begin
      sleep_enable = 1'b1;
      mean_current_low = 1'b1;
      wait_mode(3'h1, 10);
      chk("cal", cal_start, 1'b1);
      pulse(cal_done);
      sleep_enable = 1'b0;
      wait_mode(3'h2, 10);
      if (k == 0) begin
        mean_current_low = 1'b0;
      end else begin
        cnt = 0;
        while (measure_active === 1'b1 && cnt < 40) begin
          @(negedge clk);
          cnt++;
        end
        chk("measure", measure_active, 1'b0);
        cnt = 0;
        while (measure_active !== 1'b1 && cnt < 1100) begin
          @(negedge clk);
          cnt++;
        end
        chk("measure", measure_active, 1'b1);
        wake_comparator = 1'b1;
        cycles(10);
        chk("mode", power_mode, 3'h2);
        sense_select_low = 1'b1;
      end
      wait_mode(3'h0, 10);
      {mean_current_low, wake_comparator} = '0;
    end
    hib_current_low = 1'b1;
    cycles(10);
    chk("mode", power_mode, 3'h0);
    for (int k = 0; k < 3; k++) begin
      good_pin_override = 1'(k > 0);
      hibernate_request = 1'(k == 2);
      hib_current_low = 1'(k == 2);
      cell_below_hib_volt = 1'(k < 2);
      wait_mode(3'h3, 20);
      cycles(4);
      chk("good", battery_good_pin, 1'(k == 1));
      {cell_below_hib_volt, hibernate_request, hib_current_low} = '0;
      host_u.frame(1'b0);
      cycles(10);
      chk("mode", power_mode, 3'h3);
      host_u.frame(1'b1);
      @(negedge clk);
      wait_mode(3'h5, 20);
      finish_init();
      good_pin_override = 1'b0;
    end
    for (int k = 0; k < 4; k++) begin
      mem_wr_en = 1'b1;
      mem_wr_addr = 4'(k);
      mem_wr_data = 16'($random(seed));
      @(negedge clk);
      mem_wr_en = 1'b0;
      soft_reset_kind = 2'(k);
      pulse(soft_reset);
      cnt = 0;
      repeat (30) begin
        @(negedge clk);
        cnt += int'(mem_reinit === 1'b1);
      end
      chk("reinit", 8'(cnt), 8'h00);
      reset_count_sel = 2'(k);
      cycles(2);
      chk("count", reset_count, 8'h01);
    end
    // Removal passes two flops, so the voltage drop lands with it here.
    battery_present = 1'b0;
    cycles(2);
    cell_below_hib_volt = 1'b1;
    wait_mode(3'h4, 20);
    chk("gauge", gauging_active, 1'b0);
    stop_test();
  end
endmodule : gpm_seq_tb_top
bind gpm_seq gpm_seq_props props_u (.clk, .reset, .temperature,
  .inhibit_low, .inhibit_high, .suspend_low, .suspend_high, .temp_hys,
  .pin_function_code, .good_pin_override, .own_address_cmd,
  .battery_good_pin, .charge_inhibit_flag, .charge_suspend_flag,
  .power_mode);
